// file: adc_dev_model.sv
module adc_dev_model (
	// clock, reset and ack delay
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [3:0] slow,
	// register access
	input wire logic dev_req,
	input wire logic dev_we,
	input wire logic [15:0] dev_addr,
	input wire logic [7:0] dev_wdata,
	output logic dev_ack,
	output logic [7:0] dev_rdata,
	// pins
	input wire logic calib_trigger_pin,
	output logic calib_status_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [0:31];
	logic [15:0] wlog [0:63];
	int polls [0:31];
	int wcnt, wait_cnt;
	logic [7:0] rd_q;
	logic pin_q, foreground_calib_done;
	wire [4:0] a = dev_addr[4:0];
	// data only shows in the ack cycle, garbage otherwise
	assign dev_rdata = dev_ack ? rd_q : ~rd_q;
	assign calib_status_pin = foreground_calib_done;
	// flags rise after two polls, except address 23, which follows calibration done; writes are logged in order
	always @(posedge core_clk or posedge reset)
		if (reset)
		begin
			dev_ack <= 0;
			wait_cnt <= 0;
			wcnt <= 0;
			foreground_calib_done <= 0;
			pin_q <= 0;
			rd_q <= 0;
			regs <= '{default: 8'h00};
			polls <= '{default: 0};
		end
		else
		begin
			pin_q <= calib_trigger_pin;
			if (calib_trigger_pin && !pin_q && regs[22][0])
				foreground_calib_done <= 1;
			dev_ack <= 0;
			if (dev_req && !dev_ack && wait_cnt < slow)
				wait_cnt <= wait_cnt + 1;
			else if (dev_req && !dev_ack)
			begin
				wait_cnt <= 0;
				dev_ack <= 1;
				if (dev_we)
				begin
					regs[a] <= dev_wdata;
					wlog[wcnt] <= {3'b000, a, dev_wdata};
					wcnt <= wcnt + 1;
					if (a == 0)
						polls <= '{default: 0};
					if (a == 0)
						foreground_calib_done <= 0;
					if (a == 21 && dev_wdata[0] && !regs[21][0])
						foreground_calib_done <= 1;
				end
				else
				begin
					polls[a] <= polls[a] + 1;
					rd_q <= (a == 23) ? {7'h00, foreground_calib_done} : {7'h00, polls[a] >= 2};
				end
			end
		end
endmodule

// file: adc_init_consts.vh
`ifndef ADC_INIT_CONSTS_VH
`define ADC_INIT_CONSTS_VH

// apb register byte offsets of the controller
`define REG_CTRL 8'h00
`define REG_LINK 8'h04
`define REG_SYNTH 8'h08
`define REG_CALIB 8'h0c
`define REG_STATUS 8'h10

// control register field positions
`define CTRL_START 0
`define CTRL_PIN_TRIG 1
`define CTRL_LOW_POWER 2
`define CTRL_TRIGGER_CLOCK_OUTPUT 3
`define CTRL_OVR 4
`define CTRL_MANUAL_TRIM 5
`define CTRL_FG_CAL 6
`define CTRL_STAT_SEL 7
`define CTRL_POWER_DOWN 8
`define CTRL_RESET_VAL 9'h000

// device register addresses on the device access port
`define DEV_SOFT_RESET 16'h0000
`define DEV_INIT_DONE 16'h0001
`define DEV_SYNTH_RESET 16'h0002
`define DEV_OSC_BIAS 16'h0003
`define DEV_PRE_DIV 16'h0004
`define DEV_VCO_DIV 16'h0005
`define DEV_FB_DIV 16'h0006
`define DEV_TRIM_AUTO 16'h0007
`define DEV_TRIM_VALUE 16'h0008
`define DEV_LINK_EN 16'h0009
`define DEV_CAL_EN 16'h000a
`define DEV_LOW_POWER 16'h000b
`define DEV_LINK_MODE 16'h000c
`define DEV_MF_LEN 16'h000d
`define DEV_SYNC_SEL 16'h000e
`define DEV_CALIB_CONFIG_REG0 16'h000f
`define DEV_CALIB_CONFIG_REG1 16'h0010
`define DEV_TRIGGER_CLOCK_OUTPUT 16'h0011
`define DEV_TRIM_DONE 16'h0012
`define DEV_LOCK 16'h0013
`define DEV_OVR 16'h0014
`define DEV_SOFT_TRIG 16'h0015
`define DEV_PIN_TRIG_EN 16'h0016
`define DEV_FOREGROUND_CALIB_DONE 16'h0017

// device data values
`define OSC_BIAS_VALUE 8'h4a
`define BIT_ON 8'h01
`define BIT_OFF 8'h00
`define FLAG_MASK 8'h01

// how long each level of the calibration trigger pin is held
`define PIN_HOLD_CYCLES 8

`endif

// file: adc_init_ctrl.v
// Behaviour
// - board straps synthesizer use and reference input
// - power-down pin low during power-up, clock use
// - stable reference clock before device reset
// - reset, then poll init done until one
// - synth reset, bias 0x4A, then three dividers
// - trim auto or manual, then release synth reset
// - stop serial link before configuring
// - stop calibration engine before configuring
// - link mode, then multiframe length minus one
// - choose sync source input
// - calibration mode and offset settings while stopped
// - optional trigger clock output and low power
// - wait trim done and lock with synthesizer
// - enable calibration, then optional overrange
// - re-enable serial link after calibration
// - foreground trigger by register or pin edge
// - data valid after link up and calibration
//
// The address map and the APB register port were decided locally.
`include "adc_init_consts.vh"

module adc_init_ctrl #(
	parameter PIN_HOLD = `PIN_HOLD_CYCLES
) (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	// device register access port
	output reg dev_req_q,
	output reg dev_we_q,
	output reg [15:0] dev_addr_q,
	output reg [7:0] dev_wdata_q,
	input wire dev_ack,
	input wire [7:0] dev_rdata,
	// device pins and board
	input wire synth_on_strap,
	input wire ref_input_select_strap,
	input wire ref_clock_stable,
	output reg power_down_pin_q,
	output reg calib_trigger_pin_q,
	input wire calib_status_pin,
	// receiver side
	input wire rx_link_ready,
	output reg data_valid_q
);

	localparam PH_IDLE = 3'h0, PH_ISSUE = 3'h1, PH_WAIT = 3'h2, PH_HOLD = 3'h3;
	localparam OP_SKIP = 3'h0, OP_WR = 3'h1, OP_RD = 3'h2, OP_PIN = 3'h3, OP_END = 3'h4;
	localparam S_RST = 5'h00, S_INIT = 5'h01, S_SRST1 = 5'h02, S_BIAS = 5'h03, S_PRE = 5'h04;
	localparam S_VCO = 5'h05, S_FB = 5'h06, S_TAUTO = 5'h07, S_TVAL = 5'h08, S_SRST0 = 5'h09;
	localparam S_LOFF = 5'h0a, S_COFF = 5'h0b, S_LP = 5'h0c, S_MODE = 5'h0d, S_MF = 5'h0e;
	localparam S_SYNC = 5'h0f, S_CFG0 = 5'h10, S_CFG1 = 5'h11, S_TRIGO = 5'h12, S_TDONE = 5'h13;
	localparam S_LOCK = 5'h14, S_CON = 5'h15, S_OVR = 5'h16, S_LON = 5'h17, S_ST0 = 5'h18;
	localparam S_ST1 = 5'h19, S_PEN = 5'h1a, S_PLO = 5'h1b, S_PHI = 5'h1c, S_CALW = 5'h1d;
	localparam S_END = 5'h1e;
	localparam [31:0] HOLD_LAST = PIN_HOLD - 1;

	reg [8:0] ctrl_q;
	reg [31:0] link_q;
	reg [31:0] synth_q;
	reg [31:0] calib_q;
	reg start_q;
	reg [2:0] phase_q;
	reg [4:0] step_q;
	reg [7:0] hold_q;
	reg synth_use_q;
	reg done_q;
	reg fg_seen_q;
	reg [2:0] cur_op;
	reg [15:0] cur_addr;
	reg [7:0] cur_data;
	wire busy;
	wire strap_err;
	wire apb_take;
	wire pin_cal_ok;
	wire fg_sw;
	wire fg_pin;
	wire flag_set;

	assign busy = (phase_q != PH_IDLE);
	// the single-ended reference only works through the synthesizer
	assign strap_err = ref_input_select_strap & ~synth_on_strap;
	assign apb_take = psel & penable & pready_q;
	assign pin_cal_ok = calib_status_pin & ~ctrl_q[`CTRL_STAT_SEL];
	assign fg_sw = ctrl_q[`CTRL_FG_CAL] & ~ctrl_q[`CTRL_PIN_TRIG];
	assign fg_pin = ctrl_q[`CTRL_FG_CAL] & ctrl_q[`CTRL_PIN_TRIG];
	assign flag_set = ((dev_rdata & `FLAG_MASK) != `BIT_OFF);

	// step table: what each step does, optional steps fall to a skip
	always @*
	begin
		cur_op = OP_WR;
		cur_addr = `DEV_SOFT_RESET;
		cur_data = `BIT_ON;
		case (step_q)
			S_RST: cur_addr = `DEV_SOFT_RESET;
			S_INIT:
			begin
				cur_op = OP_RD;
				cur_addr = `DEV_INIT_DONE;
			end
			S_SRST1:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_SYNTH_RESET;
			end
			S_BIAS:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_OSC_BIAS;
				cur_data = `OSC_BIAS_VALUE;
			end
			S_PRE:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_PRE_DIV;
				cur_data = synth_q[7:0];
			end
			S_VCO:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_VCO_DIV;
				cur_data = synth_q[15:8];
			end
			S_FB:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_FB_DIV;
				cur_data = synth_q[23:16];
			end
			S_TAUTO:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_TRIM_AUTO;
				cur_data = ctrl_q[`CTRL_MANUAL_TRIM] ? `BIT_OFF : `BIT_ON;
			end
			S_TVAL:
			begin
				cur_op = (synth_use_q & ctrl_q[`CTRL_MANUAL_TRIM]) ? OP_WR : OP_SKIP;
				cur_addr = `DEV_TRIM_VALUE;
				cur_data = synth_q[31:24];
			end
			S_SRST0:
			begin
				cur_op = synth_use_q ? OP_WR : OP_SKIP;
				cur_addr = `DEV_SYNTH_RESET;
				cur_data = `BIT_OFF;
			end
			S_LOFF:
			begin
				cur_addr = `DEV_LINK_EN;
				cur_data = `BIT_OFF;
			end
			S_COFF:
			begin
				cur_addr = `DEV_CAL_EN;
				cur_data = `BIT_OFF;
			end
			S_LP:
			begin
				cur_op = ctrl_q[`CTRL_LOW_POWER] ? OP_WR : OP_SKIP;
				cur_addr = `DEV_LOW_POWER;
			end
			S_MODE:
			begin
				cur_addr = `DEV_LINK_MODE;
				cur_data = link_q[7:0];
			end
			S_MF:
			begin
				cur_addr = `DEV_MF_LEN;
				cur_data = link_q[15:8];
			end
			S_SYNC:
			begin
				cur_addr = `DEV_SYNC_SEL;
				cur_data = link_q[23:16];
			end
			S_CFG0:
			begin
				cur_addr = `DEV_CALIB_CONFIG_REG0;
				cur_data = calib_q[7:0];
			end
			S_CFG1:
			begin
				cur_addr = `DEV_CALIB_CONFIG_REG1;
				cur_data = calib_q[15:8];
			end
			S_TRIGO:
			begin
				cur_op = ctrl_q[`CTRL_TRIGGER_CLOCK_OUTPUT] ? OP_WR : OP_SKIP;
				cur_addr = `DEV_TRIGGER_CLOCK_OUTPUT;
				cur_data = calib_q[23:16];
			end
			S_TDONE:
			begin
				cur_op = synth_use_q ? OP_RD : OP_SKIP;
				cur_addr = `DEV_TRIM_DONE;
			end
			S_LOCK:
			begin
				cur_op = synth_use_q ? OP_RD : OP_SKIP;
				cur_addr = `DEV_LOCK;
			end
			S_CON: cur_addr = `DEV_CAL_EN;
			S_OVR:
			begin
				cur_op = ctrl_q[`CTRL_OVR] ? OP_WR : OP_SKIP;
				cur_addr = `DEV_OVR;
				cur_data = calib_q[31:24];
			end
			S_LON: cur_addr = `DEV_LINK_EN;
			S_ST0:
			begin
				cur_op = fg_sw ? OP_WR : OP_SKIP;
				cur_addr = `DEV_SOFT_TRIG;
				cur_data = `BIT_OFF;
			end
			S_ST1:
			begin
				cur_op = fg_sw ? OP_WR : OP_SKIP;
				cur_addr = `DEV_SOFT_TRIG;
			end
			S_PEN:
			begin
				cur_op = fg_pin ? OP_WR : OP_SKIP;
				cur_addr = `DEV_PIN_TRIG_EN;
			end
			S_PLO:
			begin
				cur_op = fg_pin ? OP_PIN : OP_SKIP;
				cur_data = `BIT_OFF;
			end
			S_PHI: cur_op = fg_pin ? OP_PIN : OP_SKIP;
			S_CALW:
			begin
				cur_op = ctrl_q[`CTRL_FG_CAL] ? OP_RD : OP_SKIP;
				cur_addr = `DEV_FOREGROUND_CALIB_DONE;
			end
			S_END: cur_op = OP_END;
			default: cur_op = OP_END;
		endcase
	end

	// apb slave: three-cycle access, pready one cycle after penable
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			ctrl_q <= `CTRL_RESET_VAL;
			link_q <= 32'h0000_0000;
			synth_q <= 32'h0000_0000;
			calib_q <= 32'h0000_0000;
			start_q <= 1'b0;
		end
		else
		begin
			pready_q <= psel & penable & ~pready_q;
			start_q <= 1'b0;
			if (psel & penable & ~pready_q)
			begin
				pslverr_q <= (paddr > `REG_STATUS) | (paddr[1:0] != 2'h0);
				case (paddr)
					`REG_CTRL: prdata_q <= {23'h000000, ctrl_q};
					`REG_LINK: prdata_q <= link_q;
					`REG_SYNTH: prdata_q <= synth_q;
					`REG_CALIB: prdata_q <= calib_q;
					`REG_STATUS: prdata_q <= {21'h000000, step_q, synth_use_q, fg_seen_q, data_valid_q,
						strap_err, done_q, busy};
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
			// settings only move while the sequence is idle, so no step sees a torn value
			if (apb_take & pwrite & ~busy)
			begin
				case (paddr)
					`REG_CTRL:
					begin
						ctrl_q <= {pwdata[8:1], 1'b0};
						start_q <= pwdata[`CTRL_START];
					end
					`REG_LINK: link_q <= pwdata;
					`REG_SYNTH: synth_q <= pwdata;
					`REG_CALIB: calib_q <= pwdata;
					default: start_q <= 1'b0;
				endcase
			end
		end
	end

	// sequence engine: one step at a time, each access acknowledged before the next
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			phase_q <= PH_IDLE;
			step_q <= S_RST;
			hold_q <= 8'h00;
			synth_use_q <= 1'b0;
			done_q <= 1'b0;
			fg_seen_q <= 1'b0;
			dev_req_q <= 1'b0;
			dev_we_q <= 1'b0;
			dev_addr_q <= 16'h0000;
			dev_wdata_q <= 8'h00;
			calib_trigger_pin_q <= 1'b0;
		end
		else
		begin
			case (phase_q)
				PH_IDLE:
				begin
					if (start_q & ~strap_err)
					begin
						synth_use_q <= synth_on_strap;
						step_q <= S_RST;
						done_q <= 1'b0;
						fg_seen_q <= 1'b0;
						phase_q <= PH_ISSUE;
					end
				end
				PH_ISSUE:
				begin
					case (cur_op)
						OP_WR, OP_RD:
						begin
							// no device reset until the reference clock is stable
							if ((step_q != S_RST) | ref_clock_stable)
							begin
								dev_req_q <= 1'b1;
								dev_we_q <= (cur_op == OP_WR);
								dev_addr_q <= cur_addr;
								dev_wdata_q <= cur_data;
								phase_q <= PH_WAIT;
							end
						end
						OP_PIN:
						begin
							calib_trigger_pin_q <= cur_data[0];
							hold_q <= 8'h00;
							phase_q <= PH_HOLD;
						end
						OP_END:
						begin
							done_q <= 1'b1;
							phase_q <= PH_IDLE;
						end
						default: step_q <= step_q + 5'h01;
					endcase
				end
				PH_WAIT:
				begin
					if (dev_ack)
					begin
						dev_req_q <= 1'b0;
						phase_q <= PH_ISSUE;
						// a poll repeats until the flag reads one; the S_CALW poll also ends on pin_cal_ok
						if (dev_we_q | flag_set | ((step_q == S_CALW) & pin_cal_ok))
							step_q <= step_q + 5'h01;
						if ((step_q == S_CALW) & flag_set)
							fg_seen_q <= 1'b1;
					end
				end
				PH_HOLD:
				begin
					hold_q <= hold_q + 8'h01;
					if ({24'h000000, hold_q} == HOLD_LAST)
					begin
						step_q <= step_q + 5'h01;
						phase_q <= PH_ISSUE;
					end
				end
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

	// power-down pin and data-valid; power-down only honoured while idle so clocks keep running
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			power_down_pin_q <= 1'b0;
			data_valid_q <= 1'b0;
		end
		else
		begin
			power_down_pin_q <= ctrl_q[`CTRL_POWER_DOWN] & ~busy;
			// link up (sync used by 8b/10b modes, header lock by 64b/66b) plus calibration done
			data_valid_q <= done_q & rx_link_ready & (fg_seen_q | pin_cal_ok);
		end
	end

endmodule

// file: adc_init_ctrl_chk.sv
module adc_init_ctrl_chk #(
	parameter PIN_HOLD = 8
) (
	// clock and reset
	input logic core_clk,
	input logic reset,
	// apb side
	input logic psel,
	input logic penable,
	input logic [7:0] paddr,
	input logic pready_q,
	input logic pslverr_q,
	// device port
	input logic dev_req_q,
	input logic dev_we_q,
	input logic [15:0] dev_addr_q,
	input logic [7:0] dev_wdata_q,
	input logic dev_ack,
	input logic [7:0] dev_rdata,
	// pins
	input logic synth_on_strap,
	input logic power_down_pin_q,
	input logic calib_trigger_pin_q,
	input logic rx_link_ready,
	input logic data_valid_q
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_n;
	logic lock_q, init_q;
	wire rd_one = dev_ack && !dev_we_q && dev_rdata[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// low time of the trigger pin since the last device access, so a skipped hold shows up
	always @(posedge core_clk or posedge reset)
		if (reset)
			low_n <= 0;
		else
			low_n <= (calib_trigger_pin_q || dev_req_q) ? 0 : low_n + 1;
	// lock seen since the last synth reset, init seen since soft reset
	always @(posedge core_clk or posedge reset)
		if (reset)
			lock_q <= 1'b0;
		else if (dev_ack && dev_we_q && dev_addr_q == 16'h0002)
			lock_q <= 1'b0;
		else if (rd_one && dev_addr_q == 16'h0013)
			lock_q <= 1'b1;
	always @(posedge core_clk or posedge reset)
		if (reset)
			init_q <= 1'b0;
		else if (dev_ack && dev_we_q && dev_addr_q == 16'h0000)
			init_q <= 1'b0;
		else if (rd_one && dev_addr_q == 16'h0001)
			init_q <= 1'b1;
	sequence s_wait;
		psel && penable && !pready_q;
	endsequence
	sequence s_done;
		dev_req_q && dev_ack;
	endsequence
	a_apb_answer: assert property (s_wait |=> pready_q)
		else $error("apb answer late");
	a_ready_pulse: assert property (pready_q |=> !pready_q)
		else $error("pready longer than one cycle");
	a_slverr_map: assert property (pready_q |-> pslverr_q == (paddr > 8'h10 || paddr[1:0] != 2'b00))
		else $error("slave error mismatch");
	a_req_hold: assert property (dev_req_q && !dev_ack |=> dev_req_q && $stable(dev_addr_q)
		&& $stable(dev_we_q) && $stable(dev_wdata_q))
		else $error("device request changed before ack");
	a_req_drop: assert property (s_done |=> !dev_req_q)
		else $error("request held after ack");
	a_init_first: assert property (dev_req_q && dev_addr_q > 16'h0001 |-> init_q)
		else $error("configured before init done");
	a_lock_first: assert property (dev_req_q && dev_we_q && dev_addr_q == 16'h000a && dev_wdata_q[0]
		&& synth_on_strap |-> lock_q)
		else $error("calibration enabled before lock");
	a_pd_quiet: assert property (dev_req_q |-> !power_down_pin_q)
		else $error("power down while configuring");
	a_trig_low: assert property ($rose(calib_trigger_pin_q) |-> low_n > PIN_HOLD)
		else $error("trigger pin low too short");
	a_valid_link: assert property (data_valid_q |-> $past(rx_link_ready))
		else $error("data valid without link");
endmodule
bind adc_init_ctrl adc_init_ctrl_chk #(.PIN_HOLD(PIN_HOLD)) chk_i (.core_clk, .reset, .psel, .penable, .paddr,
	.pready_q, .pslverr_q, .dev_req_q, .dev_we_q, .dev_addr_q, .dev_wdata_q, .dev_ack, .dev_rdata, .synth_on_strap,
	.power_down_pin_q, .calib_trigger_pin_q, .rx_link_ready, .data_valid_q);

// file: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err, ok;
	logic [7:0] paddr = 0, dev_wdata_q, dev_rdata;
	logic [31:0] pwdata = 0, prdata_q, rd;
	logic pready_q, pslverr_q, dev_req_q, dev_we_q, dev_ack, calib_status_pin;
	logic [15:0] dev_addr_q;
	logic synth_on_strap = 1, ref_input_select_strap = 0, ref_clock_stable = 0, rx_link_ready = 0;
	logic power_down_pin_q, calib_trigger_pin_q, data_valid_q;
	logic [3:0] slow = 3;
	logic [15:0] exp1 [$];
	int num_errors = 0, checks_done = 0, base = 0;
	adc_init_ctrl #(.PIN_HOLD(2)) uut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
		.pready_q, .pslverr_q, .dev_req_q, .dev_we_q, .dev_addr_q, .dev_wdata_q, .dev_ack, .dev_rdata,
		.synth_on_strap, .ref_input_select_strap, .ref_clock_stable, .power_down_pin_q, .calib_trigger_pin_q,
		.calib_status_pin, .rx_link_ready, .data_valid_q);
	adc_dev_model dev (.core_clk, .reset, .slow, .dev_req(dev_req_q), .dev_we(dev_we_q), .dev_addr(dev_addr_q),
		.dev_wdata(dev_wdata_q), .dev_ack, .dev_rdata, .calib_trigger_pin(calib_trigger_pin_q), .calib_status_pin);
	// 200 MHz
	initial
		forever #2.5 core_clk = ~core_clk;
	task stop_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task to;
		num_errors++;
		$display("BAD wait expected answer seen timeout");
		stop_test;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer, request held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready_q !== 1'b1 && n < 50);
		ok = pready_q;
		rd = prdata_q;
		err = pslverr_q;
		psel <= 0;
		penable <= 0;
		if (ok !== 1'b1)
			to();
		@(posedge core_clk);
	endtask
	// poll status until done and not busy
	task wait_done;
		int n;
		n = 0;
		do
		begin
			apb(0, 8'h10, 0);
			n++;
		end
		while (rd[1:0] !== 2'b10 && n < 300);
		if (rd[1:0] !== 2'b10)
			to();
	endtask
	task chk_log(input logic [15:0] e [$]);
		chk("write count", e.size(), dev.wcnt - base);
		foreach (e[i])
			chk("device write", e[i], dev.wlog[base + i]);
		base = dev.wcnt;
	endtask
	initial
	begin
		exp1 = '{16'h0001, 16'h0201, 16'h034a, 16'h0404, 16'h0502, 16'h0603, 16'h0700, 16'h085a, 16'h0200,
			16'h0900, 16'h0a00, 16'h0b01, 16'h0c08, 16'h0d1f, 16'h0e01, 16'h0f01, 16'h1002, 16'h1181, 16'h0a01,
			16'h1433, 16'h0901, 16'h1500, 16'h1501};
		repeat (20) @(posedge core_clk);
		reset <= 0;
		apb(0, 8'h00, 0);
		chk("ctrl reset", 0, rd);
		apb(0, 8'h10, 0);
		chk("status reset", 0, rd);
		apb(0, 8'h14, 0);
		chk("unmapped", 1, {rd[30:0], err});
		apb(0, 8'h02, 0);
		chk("unaligned", 1, err);
		apb(1, 8'h00, 32'h100);
		repeat (2) @(posedge core_clk);
		chk("power down", 1, power_down_pin_q);
		apb(1, 8'h00, 0);
		apb(1, 8'h04, 32'h00011f08);
		apb(1, 8'h08, 32'h5a030204);
		apb(1, 8'h0c, 32'h33810201);
		apb(0, 8'h08, 0);
		chk("synth readback", 32'h5a030204, rd);
		apb(1, 8'h00, 32'hfd);
		repeat (20) @(posedge core_clk);
		chk("writes before clock", 0, dev.wcnt);
		ref_clock_stable <= 1;
		wait_done;
		chk_log(exp1);
		chk("valid no link", 0, data_valid_q);
		rx_link_ready <= 1;
		repeat (3) @(posedge core_clk);
		chk("valid", 1, data_valid_q);
		synth_on_strap <= 0;
		slow <= 0;
		apb(1, 8'h04, 32'h00000102);
		apb(1, 8'h00, 32'h43);
		apb(1, 8'h00, 32'h100);
		chk("power down busy", 0, power_down_pin_q);
		wait_done;
		chk_log('{16'h0001, 16'h0900, 16'h0a00, 16'h0c02, 16'h0d01, 16'h0e00, 16'h0f01, 16'h1002, 16'h0a01,
			16'h0901, 16'h1601});
		apb(0, 8'h00, 0);
		chk("ctrl refused", 32'h42, rd);
		apb(0, 8'h10, 0);
		chk("status valid", 32'h8, rd & 32'h8);
		ref_input_select_strap <= 1;
		apb(1, 8'h00, 32'h1);
		repeat (4) @(posedge core_clk);
		apb(0, 8'h10, 0);
		chk("strap error", 32'h4, rd & 32'h4);
		chk("no writes", base, dev.wcnt);
		// synthesizer with automatic trim and no calibration run: link up alone is not enough
		ref_input_select_strap <= 0;
		synth_on_strap <= 1;
		apb(1, 8'h00, 32'h1);
		wait_done;
		chk_log('{16'h0001, 16'h0201, 16'h034a, 16'h0404, 16'h0502, 16'h0603, 16'h0701, 16'h0200, 16'h0900,
			16'h0a00, 16'h0c02, 16'h0d01, 16'h0e00, 16'h0f01, 16'h1002, 16'h0a01, 16'h0901});
		chk("status no cal", 32'h22, rd & 32'h3f);
		chk("valid no cal", 0, data_valid_q);
		stop_test;
	end
endmodule
